/* src/sftr_top.sv */
// Frame and line timing generator with its control registers
`timescale 1ns/10ps
`include "sftr_consts.svh"
module sftr_top
    import sftr_pkg::*;
#(
    parameter int LINE_PIXELS = `SFTR_LINE_PIX,
    parameter int FRAME_LINES = `SFTR_FRAME_LN
) (
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_reset,
    // Decoded serial control port
    input  wire sftr_req_t  i_req,
    output      logic [7:0] o_reg_rdata,
    // Channel averages from the statistics counters
    input  wire sftr_avg_t  i_avg,
    // Frame and line sync to the capture host
    output      sftr_sync_t o_sync,
    output      logic       o_frame_start
);
    // Counter widths limit the frame geometry
    if (LINE_PIXELS < 2 || LINE_PIXELS > 2048 ||
        FRAME_LINES < 2 || FRAME_LINES > 4096) begin : g_bad_size
        $error("sftr_top: counter widths cannot hold the parameters");
    end

    localparam logic [10:0] PIX_LAST = 11'(LINE_PIXELS - 1);
    localparam logic [12:0] LN_LAST  = 13'(FRAME_LINES - 1);

    localparam sftr_state_t RST_S = '{
        r: '{r_vlo: `SFTR_R_VLO, r_hsh: `SFTR_R_HSH, r_heh: `SFTR_R_HEH,
             r_vsh: `SFTR_R_VSH, r_veh: `SFTR_R_VEH, r_tx: `SFTR_R_TX,
             r_li: `SFTR_R_LI, r_vxl: `SFTR_R_VXL, r_vxh: `SFTR_R_VXH,
             r_lum: `SFTR_R_LUM, r_hsy: `SFTR_R_HSY, r_hey: `SFTR_R_HEY,
             r_hlo: `SFTR_R_HLO},
        default: '0
    };

    sftr_state_t s;
    sftr_state_t next_s;

    logic        line_end;
    logic        frame_end;
    logic [9:0]  lum_sum;
    logic [11:0] vpos;

    function automatic logic [7:0] read_reg(input logic [7:0] a,
                                            input sftr_regs_t r);
        unique case (a)
            `SFTR_A_VLO: read_reg = r.r_vlo;
            `SFTR_A_HSH: read_reg = r.r_hsh;
            `SFTR_A_HEH: read_reg = r.r_heh;
            `SFTR_A_VSH: read_reg = r.r_vsh;
            `SFTR_A_VEH: read_reg = r.r_veh;
            `SFTR_A_TX:  read_reg = r.r_tx;
            `SFTR_A_LI:  read_reg = r.r_li;
            `SFTR_A_VXL: read_reg = r.r_vxl;
            `SFTR_A_VXH: read_reg = r.r_vxh;
            `SFTR_A_LUM: read_reg = r.r_lum;
            `SFTR_A_HSY: read_reg = r.r_hsy;
            `SFTR_A_HEY: read_reg = r.r_hey;
            `SFTR_A_HLO: read_reg = r.r_hlo;
            default:     read_reg = 8'h00;
        endcase
    endfunction

    assign line_end  = (s.pix == PIX_LAST);
    assign frame_end = line_end && (s.line == LN_LAST + 13'(s.sh_adj));
    assign lum_sum   = 10'(i_avg.blue) + 10'(i_avg.green_blue)
                     + 10'(i_avg.green_red) + 10'(i_avg.red);
    assign vpos      = s.line[12:1];

    always_comb begin
        next_s = s;
        if (i_req.rd)
            next_s.rdata = read_reg(i_req.addr, s.r);
        if (i_req.wr) begin
            unique case (i_req.addr)
                `SFTR_A_VLO: next_s.r.r_vlo = i_req.wdata & `SFTR_VLO_MASK;
                `SFTR_A_HSH: next_s.r.r_hsh = i_req.wdata;
                `SFTR_A_HEH: next_s.r.r_heh = i_req.wdata;
                `SFTR_A_VSH: next_s.r.r_vsh = i_req.wdata;
                `SFTR_A_VEH: next_s.r.r_veh = i_req.wdata;
                `SFTR_A_TX:  next_s.r.r_tx  = i_req.wdata;
                `SFTR_A_LI:  next_s.r.r_li  = i_req.wdata;
                `SFTR_A_VXL: next_s.r.r_vxl = i_req.wdata;
                `SFTR_A_VXH: next_s.r.r_vxh = i_req.wdata;
                `SFTR_A_LUM: next_s.r.r_lum = i_req.wdata;
                `SFTR_A_HSY: next_s.r.r_hsy = i_req.wdata;
                `SFTR_A_HEY: next_s.r.r_hey = i_req.wdata;
                `SFTR_A_HLO: next_s.r.r_hlo = i_req.wdata & `SFTR_HLO_MASK;
                default: ;
            endcase
        end
        // Pixel and line counters
        next_s.pix = line_end ? 11'h000 : s.pix + 11'h001;
        if (line_end)
            next_s.line = frame_end ? 13'h0000 : s.line + 13'h0001;
        if (line_end && s.vcnt != 17'h00000)
            next_s.vcnt = s.vcnt - 17'h00001;
        if (frame_end) begin
            // hardware update beats a host write
            next_s.r.r_lum = lum_sum[9:2];
            next_s.sh_vs  = {s.r.r_vsh, s.r.r_vlo[`SFTR_VLO_STA]};
            next_s.sh_ve  = {s.r.r_veh, s.r.r_vlo[`SFTR_VLO_END]};
            next_s.sh_hs  = {s.r.r_hsh, s.r.r_hlo[`SFTR_HLO_STA]};
            next_s.sh_he  = {s.r.r_heh, s.r.r_hlo[`SFTR_HLO_END]};
            next_s.sh_hss = {s.r.r_tx[`SFTR_TX_HSTA], s.r.r_hsy};
            next_s.sh_hse = {s.r.r_tx[`SFTR_TX_HORIZONTAL_WINDOW_END_HIGH], s.r.r_hey};
            next_s.sh_adj = {s.r.r_tx[`SFTR_TX_ADJ], s.r.r_li};
            next_s.sh_vx  = {s.r.r_vxh, s.r.r_vxl};
            next_s.vcnt   = `SFTR_VS_BASE
                          + {1'b0, s.r.r_vxh, s.r.r_vxl};
        end
        next_s.sync.vsync = (next_s.vcnt != 17'h00000);
        next_s.sync.hsync = ({1'b0, s.pix} >= 11'(s.sh_hss))
                         && ({1'b0, s.pix} < {1'b0, s.sh_hse});
        next_s.sync.href  = (s.pix >= s.sh_hs) && (s.pix < s.sh_he)
                         && (vpos >= 12'(s.sh_vs))
                         && (vpos < 12'(s.sh_ve));
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            s <= RST_S;
        end else begin
            s <= next_s;
        end
    end

    assign o_reg_rdata   = s.rdata;
    assign o_sync        = s.sync;
    assign o_frame_start = s.sync.vsync && (s.line == 13'h0000)
                        && (s.pix == 11'h000) && (s.vcnt != 17'h00000)
                        && (s.vcnt == `SFTR_VS_BASE + {1'b0, s.sh_vx});

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    logic past_fe;
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset)
            past_fe <= 1'b0;
        else
            past_fe <= frame_end;
    end

    chk_vs_start: assert property (past_fe |->
        s.vcnt == `SFTR_VS_BASE + {1'b0, s.sh_vx} && s.sync.vsync)
        else $error("vsync width not loaded at frame start");
    chk_vs_count: assert property (past_fe |->
        s.sh_vx == {$past(s.r.r_vxh), $past(s.r.r_vxl)})
        else $error("extension count not formed from both registers");
    chk_vs_step: assert property (s.vcnt != 17'h0 && line_end &&
        !frame_end |=> s.vcnt == $past(s.vcnt) - 17'h1)
        else $error("vsync count did not drop by one line");
    chk_hs_edge: assert property (##1 s.sync.hsync ==
        ({1'b0, $past(s.pix)} >= 11'($past(s.sh_hss)) &&
         {1'b0, $past(s.pix)} < {1'b0, $past(s.sh_hse)}))
        else $error("hsync edge at wrong pixel");
    chk_frame_len: assert property (line_end &&
        s.line == LN_LAST + 13'(s.sh_adj) |=> s.line == 13'h0)
        else $error("frame did not end after adjusted line count");
    chk_shadow_hold: assert property (!frame_end |=>
        $stable(s.sh_adj) && $stable(s.sh_hss) && $stable(s.sh_ve))
        else $error("timing shadow changed inside a frame");
    chk_lum_avg: assert property (frame_end |=>
        s.r.r_lum == $past(lum_sum[9:2]))
        else $error("luminance average wrong");
    chk_href_win: assert property (s.sync.href |->
        $past(vpos) >= 12'($past(s.sh_vs)) &&
        $past(vpos) < 12'($past(s.sh_ve)))
        else $error("href outside vertical window");
    chk_rd_back: assert property (i_req.rd && !i_req.wr &&
        i_req.addr == `SFTR_A_LI |=> o_reg_rdata == s.r.r_li)
        else $error("line interval readback wrong");

    // Shadow fields are built from the registers seen at frame end
    chk_ve_form: assert property (past_fe |->
        s.sh_ve == {$past(s.r.r_veh), $past(s.r.r_vlo[`SFTR_VLO_END])})
        else $error("vertical end not formed from both registers");
    chk_vs_form: assert property (past_fe |->
        s.sh_vs == {$past(s.r.r_vsh), $past(s.r.r_vlo[`SFTR_VLO_STA])})
        else $error("vertical start not formed from both registers");
    chk_hs_form: assert property (past_fe |->
        s.sh_hs == {$past(s.r.r_hsh), $past(s.r.r_hlo[`SFTR_HLO_STA])})
        else $error("window start not formed from both registers");
    chk_he_form: assert property (past_fe |->
        s.sh_he == {$past(s.r.r_heh), $past(s.r.r_hlo[`SFTR_HLO_END])})
        else $error("window end not formed from both registers");
    chk_hss_form: assert property (past_fe |->
        s.sh_hss == {$past(s.r.r_tx[`SFTR_TX_HSTA]), $past(s.r.r_hsy)})
        else $error("hsync start not formed from both registers");
    chk_hse_form: assert property (past_fe |->
        s.sh_hse == {$past(s.r.r_tx[`SFTR_TX_HORIZONTAL_WINDOW_END_HIGH]), $past(s.r.r_hey)})
        else $error("hsync end not formed from both registers");
    chk_adj_form: assert property (past_fe |->
        s.sh_adj == {$past(s.r.r_tx[`SFTR_TX_ADJ]), $past(s.r.r_li)})
        else $error("line interval adjust not formed correctly");
    chk_vs_high: assert property (past_fe |->
        s.vcnt == `SFTR_VS_BASE + 17'({$past(s.r.r_vxh), 8'h00})
                + 17'($past(s.r.r_vxl)))
        else $error("high extension count not worth 256 lines");
    chk_shadow_rest: assert property (!frame_end |=>
        $stable(s.sh_vs) && $stable(s.sh_hs) && $stable(s.sh_he)
        && $stable(s.sh_hse) && $stable(s.sh_vx))
        else $error("window shadow changed inside a frame");

    // Counters and sync levels
    chk_pix_wrap: assert property (line_end |=> s.pix == 11'h000)
        else $error("pixel count did not wrap at line end");
    chk_pix_step: assert property (!line_end |=>
        s.pix == $past(s.pix) + 11'h001)
        else $error("pixel count did not advance by one");
    chk_line_step: assert property (line_end && !frame_end |=>
        s.line == $past(s.line) + 13'h0001)
        else $error("line count did not advance at line end");
    chk_line_hold: assert property (!line_end |=>
        $stable(s.line))
        else $error("line count moved inside a line");
    chk_line_max: assert property (
        s.line <= LN_LAST + 13'(s.sh_adj))
        else $error("line count passed the adjusted frame end");
    chk_vs_end: assert property (s.vcnt == 17'h1 && line_end &&
        !frame_end |=> !s.sync.vsync)
        else $error("vsync stayed high past its width");
    chk_fs_place: assert property (past_fe |-> o_frame_start)
        else $error("frame start missing after frame end");
    chk_fs_pulse: assert property (o_frame_start |=>
        !o_frame_start)
        else $error("frame start wider than one cycle");
    chk_href_hor: assert property (s.sync.href |->
        $past(s.pix) >= $past(s.sh_hs) && $past(s.pix) < $past(s.sh_he))
        else $error("href outside horizontal window");

    // Register port
    chk_hlo_mask: assert property (
        (s.r.r_hlo & ~`SFTR_HLO_MASK) == 8'h00)
        else $error("reserved window bits not zero");
    chk_vlo_mask: assert property (
        (s.r.r_vlo & ~`SFTR_VLO_MASK) == 8'h00)
        else $error("reserved vertical bits not zero");
    chk_wr_hlo: assert property (i_req.wr &&
        i_req.addr == `SFTR_A_HLO |=>
        s.r.r_hlo == ($past(i_req.wdata) & `SFTR_HLO_MASK))
        else $error("window low bits write lost");
    chk_wr_vlo: assert property (i_req.wr &&
        i_req.addr == `SFTR_A_VLO |=>
        s.r.r_vlo == ($past(i_req.wdata) & `SFTR_VLO_MASK))
        else $error("vertical low bits write lost");
    chk_wr_tx: assert property (i_req.wr &&
        i_req.addr == `SFTR_A_TX |=> s.r.r_tx == $past(i_req.wdata))
        else $error("timing high bits write lost");
    chk_wr_li: assert property (i_req.wr &&
        i_req.addr == `SFTR_A_LI |=> s.r.r_li == $past(i_req.wdata))
        else $error("line interval write lost");
    chk_wr_vxl: assert property (i_req.wr &&
        i_req.addr == `SFTR_A_VXL |=> s.r.r_vxl == $past(i_req.wdata))
        else $error("low extension write lost");
    chk_wr_vxh: assert property (i_req.wr &&
        i_req.addr == `SFTR_A_VXH |=> s.r.r_vxh == $past(i_req.wdata))
        else $error("high extension write lost");
    chk_rd_hold: assert property (!i_req.rd |=> $stable(o_reg_rdata))
        else $error("read data changed without a read");

    cov_frame: cover property (past_fe ##1 s.sync.vsync);
    cov_ext: cover property (past_fe && s.sh_vx != 16'h0);
    cov_href: cover property ($rose(s.sync.href));
    cov_adj: cover property (frame_end && s.sh_adj != 12'h0);
    cov_lum: cover property (frame_end ##1 s.r.r_lum != 8'h00);
endmodule

/* inc/sftr_consts.svh */
// Register offsets, reset values, field ranges and timing figures
`ifndef SFTR_CONSTS_SVH
`define SFTR_CONSTS_SVH
`define SFTR_A_VLO      8'h03
`define SFTR_A_HSH      8'h17
`define SFTR_A_HEH      8'h18
`define SFTR_A_VSH      8'h19
`define SFTR_A_VEH      8'h1A
`define SFTR_A_TX       8'h2A
`define SFTR_A_LI       8'h2B
`define SFTR_A_VXL      8'h2D
`define SFTR_A_VXH      8'h2E
`define SFTR_A_LUM      8'h2F
`define SFTR_A_HSY      8'h30
`define SFTR_A_HEY      8'h31
`define SFTR_A_HLO      8'h32
`define SFTR_R_VLO      8'h00
`define SFTR_R_HSH      8'h11
`define SFTR_R_HEH      8'h61
`define SFTR_R_VSH      8'h01
`define SFTR_R_VEH      8'h3D
`define SFTR_R_TX       8'h00
`define SFTR_R_LI       8'h00
`define SFTR_R_VXL      8'h00
`define SFTR_R_VXH      8'h00
`define SFTR_R_LUM      8'h00
`define SFTR_R_HSY      8'h08
`define SFTR_R_HEY      8'h30
`define SFTR_R_HLO      8'h2D
`define SFTR_TX_ADJ     7:4
`define SFTR_TX_HORIZONTAL_WINDOW_END_HIGH    3:2
`define SFTR_TX_HSTA    1:0
`define SFTR_HLO_END    5:3
`define SFTR_HLO_STA    2:0
`define SFTR_HLO_MASK   8'h3F
`define SFTR_VLO_END    3:2
`define SFTR_VLO_STA    1:0
`define SFTR_VLO_MASK   8'h0F
`define SFTR_VS_BASE    17'h00004
`define SFTR_LINE_PIX   800
`define SFTR_FRAME_LN   594
`endif

/* inc/sftr_pkg.sv */
// Types shared by the frame timing block
package sftr_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sftr_req_t;

    typedef struct packed {
        logic [7:0] blue;
        logic [7:0] green_blue;
        logic [7:0] green_red;
        logic [7:0] red;
    } sftr_avg_t;

    typedef struct packed {
        logic vsync;
        logic hsync;
        logic href;
    } sftr_sync_t;

    typedef struct packed {
        logic [7:0] r_vlo;
        logic [7:0] r_hsh;
        logic [7:0] r_heh;
        logic [7:0] r_vsh;
        logic [7:0] r_veh;
        logic [7:0] r_tx;
        logic [7:0] r_li;
        logic [7:0] r_vxl;
        logic [7:0] r_vxh;
        logic [7:0] r_lum;
        logic [7:0] r_hsy;
        logic [7:0] r_hey;
        logic [7:0] r_hlo;
    } sftr_regs_t;

    typedef struct packed {
        sftr_regs_t  r;
        logic [9:0]  sh_vs;
        logic [9:0]  sh_ve;
        logic [10:0] sh_hs;
        logic [10:0] sh_he;
        logic [9:0]  sh_hss;
        logic [9:0]  sh_hse;
        logic [11:0] sh_adj;
        logic [15:0] sh_vx;
        logic [10:0] pix;
        logic [12:0] line;
        logic [16:0] vcnt;
        sftr_sync_t  sync;
        logic [7:0]  rdata;
    } sftr_state_t;
endpackage

/* tb/sftr_host_model.sv */
// Capture host model measuring sync widths and frame period
`timescale 1ns/10ps
module sftr_host_model
    import sftr_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset,
    // Sync from the sensor
    input  wire sftr_sync_t  i_sync,
    input  wire logic        i_frame_start,
    // Measured widths in clock cycles
    output      logic [15:0] o_vs_len,
    output      logic [15:0] o_hs_len,
    output      logic [15:0] o_frame_len,
    output      logic [15:0] o_href_tot
);
    logic [15:0] vs_cnt;
    logic [15:0] hs_cnt;
    logic [15:0] fr_cnt;
    logic [15:0] hr_cnt;

    // Widths latch on the falling edge, totals at each frame start
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            {vs_cnt, hs_cnt, fr_cnt, hr_cnt} <= '0;
            {o_vs_len, o_hs_len, o_frame_len, o_href_tot} <= '0;
        end else begin
            vs_cnt <= i_sync.vsync ? vs_cnt + 16'h0001 : 16'h0000;
            hs_cnt <= i_sync.hsync ? hs_cnt + 16'h0001 : 16'h0000;
            if (!i_sync.vsync && vs_cnt != 16'h0000) begin
                o_vs_len <= vs_cnt;
            end
            if (!i_sync.hsync && hs_cnt != 16'h0000) begin
                o_hs_len <= hs_cnt;
            end
            fr_cnt <= i_frame_start ? 16'h0001 : fr_cnt + 16'h0001;
            hr_cnt <= (i_frame_start ? 16'h0000 : hr_cnt)
                      + {15'h0000, i_sync.href};
            if (i_frame_start) begin
                o_frame_len <= fr_cnt;
                o_href_tot  <= hr_cnt;
            end
        end
    end
endmodule

/* tb/tb_sftr_top.sv */
// Testbench for the frame timing block with a capture host model
`timescale 1ns/10ps
`include "sftr_consts.svh"
module tb_sftr_top;
    import sftr_pkg::*;
    localparam int LP = 16;
    localparam int FL = 8;
    logic        i_clk_sys = 1'b0;
    logic        i_reset   = 1'b1;
    sftr_req_t   i_req     = '0;
    sftr_avg_t   i_avg     = {8'hFF, 8'hFF, 8'hFF, 8'hFD};
    logic [7:0]  o_reg_rdata;
    sftr_sync_t  o_sync;
    logic        o_frame_start;
    logic [15:0] vs_len, hs_len, fr_len, hr_tot;
    int          fail_count = 0;
    int          checked = 0;
    int          cyc = 0;
    logic [15:0] rst_tab [13] = '{{`SFTR_A_VLO, `SFTR_R_VLO},
        {`SFTR_A_HSH, `SFTR_R_HSH}, {`SFTR_A_HEH, `SFTR_R_HEH},
        {`SFTR_A_VSH, `SFTR_R_VSH}, {`SFTR_A_VEH, `SFTR_R_VEH},
        {`SFTR_A_TX, `SFTR_R_TX}, {`SFTR_A_LI, `SFTR_R_LI},
        {`SFTR_A_VXL, `SFTR_R_VXL}, {`SFTR_A_VXH, `SFTR_R_VXH},
        {`SFTR_A_LUM, `SFTR_R_LUM}, {`SFTR_A_HSY, `SFTR_R_HSY},
        {`SFTR_A_HEY, `SFTR_R_HEY}, {`SFTR_A_HLO, `SFTR_R_HLO}};
    logic [15:0] set_tab [8] = '{{`SFTR_A_VLO, 8'h04},
        {`SFTR_A_HLO, 8'h32}, {`SFTR_A_HSH, 8'h00}, {`SFTR_A_HEH, 8'h00},
        {`SFTR_A_VSH, 8'h00}, {`SFTR_A_VEH, 8'h00},
        {`SFTR_A_HSY, 8'h03}, {`SFTR_A_HEY, 8'h09}};

    always #4 i_clk_sys = ~i_clk_sys;

    sftr_top #(.LINE_PIXELS(LP), .FRAME_LINES(FL)) i_sftr_top (
        .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_req(i_req),
        .o_reg_rdata(o_reg_rdata), .i_avg(i_avg), .o_sync(o_sync),
        .o_frame_start(o_frame_start));
    sftr_host_model i_sftr_host_model (
        .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_sync(o_sync),
        .i_frame_start(o_frame_start), .o_vs_len(vs_len),
        .o_hs_len(hs_len), .o_frame_len(fr_len), .o_href_tot(hr_tot));

    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        #1 i_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk_sys);
        #1 i_req = '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk_sys);
        #1 i_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_clk_sys);
        #1 i_req = '0;
        cmp8(o_reg_rdata, exp);
    endtask

    // Skips n frame starts, then lets the host model latch
    task automatic wait_fs(input int n);
        repeat (n) begin
            @(posedge i_clk_sys);
            #1;
            while (o_frame_start !== 1'b1) begin
                @(posedge i_clk_sys);
                #1;
            end
        end
        @(posedge i_clk_sys);
        #1;
    endtask

    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            final_report();
        end
    end

    initial begin
        repeat (10) @(posedge i_clk_sys);
        #1 i_reset = 1'b0;
        for (int k = 0; k < 13; k++) begin
            rd(rst_tab[k][15:8], rst_tab[k][7:0]);
        end
        rd(8'h2C, 8'h00);
        wr(`SFTR_A_HLO, 8'hFF);
        rd(`SFTR_A_HLO, 8'h3F);
        wr(`SFTR_A_VLO, 8'hFF);
        rd(`SFTR_A_VLO, 8'h0F);
        wr(8'h2C, 8'h55);
        rd(8'h2C, 8'h00);
        for (int k = 0; k < 8; k++) begin
            wr(set_tab[k][15:8], set_tab[k][7:0]);
        end
        wait_fs(3);
        cmp16(fr_len, 16'(LP * FL));
        cmp16(vs_len, 16'(4 * LP));
        cmp16(hs_len, 16'h0006);
        cmp16(hr_tot, 16'h0008);
        rd(`SFTR_A_LUM, 8'hFE);
        i_avg = {8'h01, 8'h02, 8'h03, 8'h04};
        wr(`SFTR_A_LI, 8'h03);
        wr(`SFTR_A_VXL, 8'h03);
        wr(`SFTR_A_TX, 8'h04);
        wr(`SFTR_A_VEH, 8'h01);
        wait_fs(1);
        cmp16(fr_len, 16'(LP * FL));
        wait_fs(2);
        cmp16(fr_len, 16'(LP * (FL + 3)));
        cmp16(vs_len, 16'(7 * LP));
        cmp16(hs_len, 16'(LP - 3));
        cmp16(hr_tot, 16'(4 * 2 * 5));
        rd(`SFTR_A_LUM, 8'h02);
        wr(`SFTR_A_TX, 8'h10);
        wr(`SFTR_A_LI, 8'h00);
        wr(`SFTR_A_VXL, 8'h00);
        wr(`SFTR_A_VXH, 8'h01);
        wait_fs(3);
        cmp16(fr_len, 16'(LP * (FL + 256)));
        cmp16(vs_len, 16'(260 * LP));
        final_report();
    end
endmodule
